// [hdl/nvac_controller.v]
// data non-volatile store access controller: registers, store and cycle sequencer
//
// Function
// - store holds 32 bytes, reachable only through the three registers
// - one byte per transfer; address and data in bank 0, control in bank 1
// - address register holds five bits, reset zero, top three read zero
// - data register is eight-bit read/write, reset zero
// - control bit 3 is write enable; reset zero; upper four bits read zero
// - setting bit 2 starts a write; hardware clears it at completion
// - write trigger ignored unless write enable already set
// - control bit 1 is read enable, reset zero; clear inhibits reads
// - bit 0 starts read only with read enable set; cleared when done
// - read byte lands in data register and stays until next operation
// - write length set by an internal timer; done shown by trigger clearing
// - power-up clears write enable
// - end of write sets write-done flag and multi-function flag
// - vector request only with all enables set and stack not full
// - servicing clears only multi-function flag; software clears write-done
// - bank bit picks bank; direct access always bank 0
`timescale 1ns/1ps
`default_nettype none
`include "nvac_defines.vh"

module nvac_controller #(
  parameter integer WRITE_CYCLES = `NVAC_WRITE_CYCLES,
  parameter integer DEPTH        = 32,
  parameter integer AW           = 5
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // core register access
  input  wire [7:0] reg_addr,
  input  wire       reg_indirect,
  input  wire       bank_select_bit,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // interrupt side
  input  wire       global_interrupt_enable,
  input  wire       write_done_int_enable,
  input  wire       mf_int_enable,
  input  wire       stack_full,
  input  wire       mf_int_serviced,
  input  wire       write_done_flag_clr,
  output reg        write_done_flag,
  output reg        mf_int_flag,
  output reg        int_vector_req,
  // status
  output reg        busy
);

  // --------------------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_READ  = 3'b010;
  localparam [2:0] ST_WRITE = 3'b100;
  localparam [31:0] WR_LAST = WRITE_CYCLES - 1;
  localparam [31:0] RD_LAST = `NVAC_READ_CYCLES - 1;

  reg [7:0]    store [0:DEPTH-1];
  reg [AW-1:0] nv_address_reg;
  reg [7:0]    nv_data_reg;
  reg          write_enable_bit_reg;
  reg          write_trig_reg;
  reg          read_enable_bit_reg;
  reg          read_trig_reg;
  reg [2:0]    state_reg;
  reg [31:0]   timer_reg;
  reg [AW-1:0] cyc_addr_reg;
  reg [7:0]    cyc_data_reg;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // direct access ignores the bank bit, so control is reachable only indirectly
  wire in_bank1 = reg_indirect & (bank_select_bit == `NVAC_BANK1);
  wire hit_addr = ~in_bank1 & (reg_addr == `NVAC_ADDR_OFFSET);
  wire hit_data = ~in_bank1 & (reg_addr == `NVAC_DATA_OFFSET);
  wire hit_ctrl = in_bank1 & (reg_addr == `NVAC_CTRL_OFFSET);

  wire ctrl_wr  = reg_wr & hit_ctrl;
  // triggers only honour an enable already set before this write
  wire wr_start = ctrl_wr & reg_wdata[`NVAC_CTRL_WR_TRIG] & write_enable_bit_reg
                  & (state_reg == ST_IDLE);
  wire rd_start = ctrl_wr & reg_wdata[`NVAC_CTRL_RD_TRIG] & read_enable_bit_reg
                  & (state_reg == ST_IDLE) & ~wr_start;
  wire wr_done  = (state_reg == ST_WRITE) & (timer_reg == WR_LAST);
  wire rd_done  = (state_reg == ST_READ) & (timer_reg == RD_LAST);

  // --------------------------------------------------------------------------
  // next values of the software registers
  // --------------------------------------------------------------------------
  reg [AW-1:0] nv_address_next;
  reg [7:0]    nv_data_next;
  reg          write_enable_bit_next;
  reg          read_enable_bit_next;
  reg          write_trig_next;
  reg          read_trig_next;

  always @* begin
    nv_address_next = nv_address_reg;
    if (reg_wr && hit_addr) begin
      nv_address_next = reg_wdata[AW-1:0];
    end
  end

  // a finished read lands over a software data write in the same cycle
  always @* begin
    nv_data_next = nv_data_reg;
    if (reg_wr && hit_data) begin
      nv_data_next = reg_wdata;
    end
    if (rd_done) begin
      nv_data_next = store[cyc_addr_reg];
    end
  end

  // enables follow every control write, even while a cycle runs
  always @* begin
    write_enable_bit_next = write_enable_bit_reg;
    read_enable_bit_next  = read_enable_bit_reg;
    if (ctrl_wr) begin
      write_enable_bit_next = reg_wdata[`NVAC_CTRL_WR_EN];
      read_enable_bit_next  = reg_wdata[`NVAC_CTRL_RD_EN];
    end
  end

  // a running trigger cannot be cleared by software mid-cycle
  always @* begin
    write_trig_next = write_trig_reg;
    if (wr_start) begin
      write_trig_next = 1'b1;
    end else if (wr_done) begin
      write_trig_next = 1'b0;
    end
  end

  always @* begin
    read_trig_next = read_trig_reg;
    if (rd_start) begin
      read_trig_next = 1'b1;
    end else if (rd_done) begin
      read_trig_next = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------------
  reg [2:0]    state_next;
  reg [31:0]   timer_next;
  reg [AW-1:0] cyc_addr_next;
  reg [7:0]    cyc_data_next;

  always @* begin
    state_next    = state_reg;
    timer_next    = timer_reg;
    cyc_addr_next = cyc_addr_reg;
    cyc_data_next = cyc_data_reg;
    case (state_reg)
      ST_IDLE: begin
        timer_next = 32'h00000000;
        if (wr_start) begin
          state_next    = ST_WRITE;
          cyc_addr_next = nv_address_reg;
          cyc_data_next = nv_data_reg;
        end else if (rd_start) begin
          state_next    = ST_READ;
          cyc_addr_next = nv_address_reg;
        end
      end
      ST_WRITE: begin
        // stands in for the store's own write timer; length is a parameter
        timer_next = timer_reg + 32'h00000001;
        if (wr_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        timer_next = timer_reg + 32'h00000001;
        if (rd_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // next values of the interrupt flags and status
  // --------------------------------------------------------------------------
  reg          write_done_flag_next;
  reg          mf_int_flag_next;
  reg          int_vector_req_next;
  reg          busy_next;

  // set wins over a clear arriving in the same cycle
  always @* begin
    write_done_flag_next = write_done_flag;
    if (wr_done) begin
      write_done_flag_next = 1'b1;
    end else if (write_done_flag_clr) begin
      write_done_flag_next = 1'b0;
    end
  end

  always @* begin
    mf_int_flag_next = mf_int_flag;
    if (wr_done) begin
      mf_int_flag_next = 1'b1;
    end else if (mf_int_serviced) begin
      mf_int_flag_next = 1'b0;
    end
  end

  // a request being serviced is withdrawn at once, not one cycle late
  always @* begin
    int_vector_req_next = global_interrupt_enable & write_done_int_enable
                          & mf_int_enable & ~stack_full
                          & write_done_flag & mf_int_flag & ~mf_int_serviced;
    busy_next           = (state_reg != ST_IDLE) | wr_start | rd_start;
  end

  // --------------------------------------------------------------------------
  // register stage
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nv_address_reg <= `NVAC_ADDR_RESET;
    end else begin
      nv_address_reg <= nv_address_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nv_data_reg <= `NVAC_DATA_RESET;
    end else begin
      nv_data_reg <= nv_data_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_bit_reg <= 1'b0;
      read_enable_bit_reg  <= 1'b0;
    end else begin
      write_enable_bit_reg <= write_enable_bit_next;
      read_enable_bit_reg  <= read_enable_bit_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_trig_reg <= 1'b0;
      read_trig_reg  <= 1'b0;
    end else begin
      write_trig_reg <= write_trig_next;
      read_trig_reg  <= read_trig_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_addr_reg <= {AW{1'b0}};
      cyc_data_reg <= 8'h00;
    end else begin
      cyc_addr_reg <= cyc_addr_next;
      cyc_data_reg <= cyc_data_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_done_flag <= 1'b0;
    end else begin
      write_done_flag <= write_done_flag_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mf_int_flag <= 1'b0;
    end else begin
      mf_int_flag <= mf_int_flag_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_vector_req <= 1'b0;
    end else begin
      int_vector_req <= int_vector_req_next;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_next;
    end
  end

  // store contents survive reset, as the real array would
  always @(posedge clk_sys) begin
    if (wr_done) begin
      store[cyc_addr_reg] <= cyc_data_reg;
    end
  end

  // --------------------------------------------------------------------------
  // read-back, registered
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (hit_addr) begin
      reg_rdata <= {{(8-AW){1'b0}}, nv_address_reg};
    end else if (hit_data) begin
      reg_rdata <= nv_data_reg;
    end else if (hit_ctrl) begin
      reg_rdata <= {4'h0, write_enable_bit_reg, write_trig_reg,
                    read_enable_bit_reg, read_trig_reg};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [hdl/nvac_defines.vh]
// constants for the data non-volatile store access controller
`ifndef NVAC_DEFINES_VH
`define NVAC_DEFINES_VH

// --------------------------------------------------------------------------
// register locations
// --------------------------------------------------------------------------
`define NVAC_CTRL_OFFSET     8'h40
`define NVAC_ADDR_OFFSET     8'h00
`define NVAC_DATA_OFFSET     8'h01
`define NVAC_BANK0           1'b0
`define NVAC_BANK1           1'b1

// --------------------------------------------------------------------------
// control fields and reset values
// --------------------------------------------------------------------------
`define NVAC_CTRL_RD_TRIG    0
`define NVAC_CTRL_RD_EN      1
`define NVAC_CTRL_WR_TRIG    2
`define NVAC_CTRL_WR_EN      3
`define NVAC_CTRL_RESET      4'h0
`define NVAC_ADDR_RESET      5'h00
`define NVAC_DATA_RESET      8'h00

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define NVAC_CLK_MHZ         25
`define NVAC_WRITE_TIME_US   2000
`define NVAC_WRITE_CYCLES    (`NVAC_WRITE_TIME_US * `NVAC_CLK_MHZ)
`define NVAC_READ_CYCLES     2

`endif

// [verification/nvac_chk.sv]
// checker for the store access controller ports
`timescale 1ns/1ps
`default_nettype none
module nvac_chk #(
  parameter integer WRITE_CYCLES = 8
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic       reg_indirect,
  input wire logic       bank_select_bit,
  input wire logic [7:0] reg_rdata,
  // interrupt side
  input wire logic       global_interrupt_enable,
  input wire logic       write_done_int_enable,
  input wire logic       mf_int_enable,
  input wire logic       stack_full,
  input wire logic       mf_int_serviced,
  input wire logic       write_done_flag_clr,
  input wire logic       write_done_flag,
  input wire logic       mf_int_flag,
  input wire logic       int_vector_req,
  input wire logic       busy
);
  // margin for the extra busy cycle after a write ends
  localparam int WMAX = WRITE_CYCLES + 4;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_was_busy;
    $past(busy);
  endsequence
  sequence s_ctrl_sel;
    $past(reg_addr) == 8'h40 && $past(reg_indirect) && $past(bank_select_bit);
  endsequence
  property p_busy_len; $rose(busy) |-> ##[1:WMAX] !busy; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy never ends");
  property p_flags; $rose(write_done_flag) |-> mf_int_flag ##0 s_was_busy; endproperty
  a_flags: assert property (p_flags) else $error("done flags not paired");
  property p_vec;
    int_vector_req == ($past(global_interrupt_enable) && $past(write_done_int_enable)
                       && $past(mf_int_enable) && !$past(stack_full)
                       && $past(write_done_flag) && $past(mf_int_flag)
                       && !$past(mf_int_serviced));
  endproperty
  a_vec: assert property (p_vec) else $error("vector without enables");
  property p_svc; mf_int_serviced && !busy |=> !mf_int_flag; endproperty
  a_svc: assert property (p_svc) else $error("shared flag kept");
  property p_keep;
    mf_int_serviced && !write_done_flag_clr && write_done_flag |=> write_done_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("done flag lost on service");
  property p_wdclr; write_done_flag_clr && !busy |=> !write_done_flag; endproperty
  a_wdclr: assert property (p_wdclr) else $error("done flag not cleared");
  property p_direct;
    $past(reg_addr) == 8'h40 && !$past(reg_indirect) |-> reg_rdata == 8'h00;
  endproperty
  a_direct: assert property (p_direct) else $error("control seen directly");
  property p_addr_top;
    $past(reg_addr) == 8'h00 && !$past(reg_indirect) |-> reg_rdata[7:5] == 3'h0;
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("address top bits set");
  property p_ctrl_top; s_ctrl_sel |-> reg_rdata[7:4] == 4'h0; endproperty
  a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");
endmodule
bind nvac_controller nvac_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_indirect(reg_indirect),
  .bank_select_bit(bank_select_bit), .reg_rdata(reg_rdata),
  .global_interrupt_enable(global_interrupt_enable), .stack_full(stack_full),
  .write_done_int_enable(write_done_int_enable), .mf_int_enable(mf_int_enable),
  .mf_int_serviced(mf_int_serviced), .write_done_flag_clr(write_done_flag_clr),
  .write_done_flag(write_done_flag), .mf_int_flag(mf_int_flag),
  .int_vector_req(int_vector_req), .busy(busy));
`default_nettype wire

// [verification/nvac_core_model.sv]
// core model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module nvac_core_model (
  // clock
  input  wire logic       clk_sys,
  // register access
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic       reg_indirect = 1'b0,
  output var  logic       bank_select_bit = 1'b0,
  output var  logic       reg_wr = 1'b0,
  output var  logic [7:0] reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata
);
  task automatic wr(input logic [7:0] a, input logic ind, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_indirect <= ind;
    bank_select_bit <= ind;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // stale data is not left on the bus
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic ind, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_indirect <= ind;
    bank_select_bit <= ind;
    @(posedge clk_sys);
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// [verification/test_data_eeprom_access_controller.sv]
// self-checking bench for the store access controller
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_access_controller;
  localparam integer WCYC = 8;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       gie = 1'b1;
  logic       stack_full = 1'b1;
  logic       svc = 1'b0;
  logic       wd_clr = 1'b0;
  logic       dee = 1'b1;
  logic       mfe = 1'b1;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_indirect, bank_select_bit, reg_wr, wd_flag, mf_flag, vec, busy;
  int         err_count = 0;
  int         checks_done = 0;
  logic [7:0] rv;
  int         n;
  always #20 clk_sys = ~clk_sys;
  nvac_core_model core (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_indirect(reg_indirect),
    .bank_select_bit(bank_select_bit), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  nvac_controller #(.WRITE_CYCLES(WCYC)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_indirect(reg_indirect), .bank_select_bit(bank_select_bit),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .global_interrupt_enable(gie), .write_done_int_enable(dee), .mf_int_enable(mfe),
    .stack_full(stack_full), .mf_int_serviced(svc), .write_done_flag_clr(wd_clr),
    .write_done_flag(wd_flag), .mf_int_flag(mf_flag), .int_vector_req(vec), .busy(busy));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic ind, input logic [7:0] e, input string nm);
    core.rd(a, ind, rv);
    chk(nm, e, rv);
  endtask
  task automatic ctl(input logic [7:0] d);
    core.wr(8'h40, 1'b1, d);
  endtask
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(8'h00, 1'b0, 8'h00, "addr_rst");
    rdc(8'h01, 1'b0, 8'h00, "data_rst");
    rdc(8'h40, 1'b1, 8'h00, "ctrl_rst");
    rdc(8'h40, 1'b0, 8'h00, "ctrl_direct");
    core.wr(8'h00, 1'b0, 8'hFF);
    rdc(8'h00, 1'b0, 8'h1F, "addr_mask");
    core.wr(8'h01, 1'b0, 8'h5A);
    rdc(8'h01, 1'b0, 8'h5A, "data_rw");
    ctl(8'h04);
    ctl(8'h01);
    rdc(8'h40, 1'b1, 8'h00, "trig_no_en");
    chk("busy_idle", 8'h00, {7'h00, busy});
    @(posedge clk_sys) gie <= 1'b0;
    ctl(8'h08);
    ctl(8'h0C);
    gie <= 1'b1;
    @(negedge clk_sys) chk("busy_wr", 8'h01, {7'h00, busy});
    repeat (WCYC - 1) @(posedge clk_sys);
    @(negedge clk_sys) chk("wd_early", 8'h00, {7'h00, wd_flag});
    @(negedge clk_sys) chk("wd_flag", 8'h01, {7'h00, wd_flag});
    chk("mf_flag", 8'h01, {7'h00, mf_flag});
    rdc(8'h40, 1'b1, 8'h08, "wr_trig_clr");
    chk("vec_full", 8'h00, {7'h00, vec});
    @(posedge clk_sys) stack_full <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) chk("vec", 8'h01, {7'h00, vec});
    @(posedge clk_sys) gie <= 1'b0;
    @(posedge clk_sys) gie <= 1'b1;
    @(negedge clk_sys) chk("vec_gie", 8'h00, {7'h00, vec});
    @(posedge clk_sys) dee <= 1'b0;
    @(posedge clk_sys) dee <= 1'b1;
    @(negedge clk_sys) chk("vec_dee", 8'h00, {7'h00, vec});
    @(posedge clk_sys) mfe <= 1'b0;
    @(posedge clk_sys) mfe <= 1'b1;
    @(negedge clk_sys) chk("vec_mfe", 8'h00, {7'h00, vec});
    @(posedge clk_sys) svc <= 1'b1;
    @(posedge clk_sys) svc <= 1'b0;
    @(negedge clk_sys) chk("svc_mf", 8'h00, {7'h00, mf_flag});
    chk("svc_wd", 8'h01, {7'h00, wd_flag});
    @(posedge clk_sys) wd_clr <= 1'b1;
    @(posedge clk_sys) wd_clr <= 1'b0;
    @(negedge clk_sys) chk("wd_clr", 8'h00, {7'h00, wd_flag});
    core.wr(8'h01, 1'b0, 8'h00);
    ctl(8'h02);
    ctl(8'h03);
    rv = 8'h01;
    n = 0;
    while (rv[0] === 1'b1 && n < 10) begin
      core.rd(8'h40, 1'b1, rv);
      n++;
    end
    chk("rd_trig_clr", 8'h02, rv);
    rdc(8'h01, 1'b0, 8'h5A, "rd_data");
    rdc(8'h01, 1'b0, 8'h5A, "rd_hold");
    chk("busy_end", 8'h00, {7'h00, busy});
    ctl(8'h08);
    rdc(8'h40, 1'b1, 8'h08, "wen_set");
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(8'h40, 1'b1, 8'h00, "wen_rst");
    rdc(8'h01, 1'b0, 8'h00, "data_rst2");
    test_done;
  end
endmodule
`default_nettype wire
